//--- logic/sac_buf2.v
// two-entry buffer carrying conversion results to the serial readout
`timescale 1ns/1ns
`include "sac_defines.vh"

module sac_buf2 (
    input  wire             clock,     // system clock
    input  wire             rst_n,     // synchronised reset, active low
    input  wire             flush,     // drop all entries
    input  wire [`SAC_MSB:0] in_data,  // word offered by the converter
    input  wire             in_valid,  // converter offers a word
    output wire             in_ready,  // room for a word
    output wire [`SAC_MSB:0] out_data, // oldest stored word
    output wire             out_valid, // a word is stored
    input  wire             out_ready  // readout takes the word
);

    reg [`SAC_MSB:0] mem_q [0:1]; // storage entries
    reg              wp_q;        // write index
    reg              rp_q;        // read index
    reg [1:0]        cnt_q;       // entries held

    wire push = in_valid & in_ready;   // word accepted
    wire pop  = out_valid & out_ready; // word delivered

    assign in_ready  = (cnt_q != `SAC_BUF_FULL);
    assign out_valid = (cnt_q != `SAC_BUF_EMPTY);
    assign out_data  = mem_q[rp_q];

    // ==========================================================
    // pointers and fill count
    always @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            wp_q  <= 1'b0;
            rp_q  <= 1'b0;
            cnt_q <= `SAC_BUF_EMPTY;
        end else if (flush) begin
            wp_q  <= 1'b0;
            rp_q  <= 1'b0;
            cnt_q <= `SAC_BUF_EMPTY;
        end else begin
            if (push)
                wp_q <= ~wp_q;
            if (pop)
                rp_q <= ~rp_q;
            if (push & ~pop)
                cnt_q <= cnt_q + `SAC_BUF_ONE;
            else if (pop & ~push)
                cnt_q <= cnt_q - `SAC_BUF_ONE;
        end
    end

    // ==========================================================
    // entry storage, written at the write index
    genvar gi;
    generate
        for (gi = 0; gi < 2; gi = gi + 1) begin : g_ent
            always @(posedge clock or negedge rst_n) begin
                if (!rst_n)
                    mem_q[gi] <= `SAC_CODE_ZERO;
                else if (push && (wp_q == gi))
                    mem_q[gi] <= in_data;
            end
        end
    endgenerate

endmodule

//--- logic/sac_ctrl.v
// control logic of a 10-bit successive-approximation converter
`timescale 1ns/1ns
`include "sac_defines.vh"

module sac_ctrl (
    input  wire             clock,             // 25 mhz system clock
    input  wire             arst_n,            // asynchronous reset, active low
    input  wire             convert_start_pin, // start pin from host
    input  wire             serial_clock,      // host serial clock pin
    input  wire             diff_part,         // strap: differential input variant
    input  wire             cmp_hi,            // comparator: sample above dac level
    output reg              powered_q,         // analog core powered
    output reg              track_q,           // capacitors follow the inputs
    output reg              pos_to_second_q,   // positive cap on second channel
    output reg              neg_to_input_q,    // negative cap on negative input
    output reg              bipolar_q,         // bipolar coding active
    output reg  [`SAC_MSB:0] dac_code_q,       // trial code for the dac
    output reg              dout_q,            // serial data output value
    output reg              dout_oe_q          // serial data output enable
);

    // the derived count is an integer, so only its low bits are kept on purpose
    localparam integer BIT_CYC_I = `SAC_BIT_CYC;  // cycles per decided bit
    localparam [3:0]   BIT_CYC   = BIT_CYC_I[3:0]; // same, at counter width

    // ==========================================================
    // reset release
    reg rst_m_q; // first reset stage
    reg rst_n_q; // reset used by the design
    always @(posedge clock or negedge arst_n) begin
        if (!arst_n) begin
            rst_m_q <= 1'b0;
            rst_n_q <= 1'b0;
        end else begin
            rst_m_q <= 1'b1;
            rst_n_q <= rst_m_q;
        end
    end

    // ==========================================================
    // pin synchronisers, two stages per pin
    wire [3:0] pin_raw = {cmp_hi, diff_part, serial_clock, convert_start_pin};
    reg  [3:0] sy1_q;  // first stage, read only by the second
    reg  [3:0] sy2_q;  // synchronised pins
    genvar gi;
    generate
        for (gi = 0; gi < 4; gi = gi + 1) begin : g_sync
            always @(posedge clock or negedge rst_n_q) begin
                if (!rst_n_q) begin
                    sy1_q[gi] <= 1'b0;
                    sy2_q[gi] <= 1'b0;
                end else begin
                    sy1_q[gi] <= pin_raw[gi];
                    sy2_q[gi] <= sy1_q[gi];
                end
            end
        end
    endgenerate

    reg  cs_last_q;  // previous start level
    reg  sck_last_q; // previous serial clock level
    always @(posedge clock or negedge rst_n_q) begin
        if (!rst_n_q) begin
            cs_last_q  <= 1'b0;
            sck_last_q <= 1'b0;
        end else begin
            cs_last_q  <= sy2_q[0];
            sck_last_q <= sy2_q[1];
        end
    end

    wire cs_rise  = sy2_q[0] & ~cs_last_q;  // start pin rose
    wire cs_fall  = ~sy2_q[0] & cs_last_q;  // start pin fell
    wire sck_rise = sy2_q[1] & ~sck_last_q; // host sampling edge
    wire sck_fall = ~sy2_q[1] & sck_last_q; // output change edge
    wire cmp_s    = sy2_q[3];               // synchronised comparator

    // ==========================================================
    // conversion state machine
    reg  [1:0]        st_q;    // control state
    reg  [3:0]        step_q;  // cycles spent on the current bit
    reg  [3:0]        idx_q;   // bit under decision
    reg  [3:0]        nbit_q;  // bits shifted out since last start
    wire [`SAC_MSB:0] trial = `SAC_ONE_TRIAL << idx_q; // weight being tried
    wire              buf_in_ready;                     // buffer has room
    wire [`SAC_MSB:0] result = {dac_code_q[`SAC_MSB] ^ bipolar_q,
                                dac_code_q[`SAC_MSB-1:0]};
    reg  [`SAC_MSB:0] dac_d;   // next trial code

    // next trial code after a bit decision
    always @* begin
        dac_d = dac_code_q;
        if (!cmp_s)
            dac_d = dac_d & ~trial;
        if (idx_q != `SAC_CNT_ZERO)
            dac_d = dac_d | (trial >> 1);
    end

    // state, sampler switches and approximation
    always @(posedge clock or negedge rst_n_q) begin
        if (!rst_n_q) begin
            st_q            <= `SAC_ST_SHUT;
            powered_q       <= 1'b0;
            track_q         <= 1'b0;
            pos_to_second_q <= 1'b0;
            neg_to_input_q  <= 1'b0;
            bipolar_q       <= 1'b0;
            dac_code_q      <= `SAC_CODE_ZERO;
            step_q          <= `SAC_CNT_ZERO;
            idx_q           <= `SAC_CNT_ZERO;
        end else if (cs_rise) begin
            // a rise aborts any conversion and starts tracking
            st_q            <= `SAC_ST_TRACK;
            powered_q       <= 1'b1;
            track_q         <= 1'b1;
            // fewer than twelve bits read picks the alternate input, or bipolar coding on the differential variant
            pos_to_second_q <= (nbit_q < `SAC_BITS_FULL) & ~sy2_q[2];
            bipolar_q       <= (nbit_q < `SAC_BITS_FULL) & sy2_q[2];
            neg_to_input_q  <= sy2_q[2];
        end else begin
            case (st_q)
                `SAC_ST_TRACK: begin
                    if (cs_fall) begin
                        // hold the sample and begin at the msb trial
                        st_q       <= `SAC_ST_CONV;
                        track_q    <= 1'b0;
                        dac_code_q <= `SAC_MSB_TRIAL;
                        // start index at data width minus one, the msb of the result
                        idx_q      <= `SAC_BITS_DATA - `SAC_CNT_ONE;
                        step_q     <= `SAC_CNT_ZERO;
                    end
                end
                `SAC_ST_CONV: begin
                    // internal pacing, one bit per BIT_CYC cycles
                    if (step_q == BIT_CYC - `SAC_CNT_ONE) begin
                        step_q     <= `SAC_CNT_ZERO;
                        dac_code_q <= dac_d;
                        if (idx_q == `SAC_CNT_ZERO)
                            st_q <= `SAC_ST_PUSH;
                        else
                            idx_q <= idx_q - `SAC_CNT_ONE;
                    end else begin
                        step_q <= step_q + `SAC_CNT_ONE;
                    end
                end
                `SAC_ST_PUSH: begin
                    // hand the word over, then power down
                    if (buf_in_ready) begin
                        st_q      <= `SAC_ST_SHUT;
                        powered_q <= 1'b0;
                    end
                end
                default: begin
                    st_q <= `SAC_ST_SHUT;
                end
            endcase
        end
    end

    // ==========================================================
    // result buffer between converter and readout
    wire [`SAC_MSB:0] buf_data;  // oldest result
    wire              buf_valid; // result available
    reg               loaded_q;  // shifter holds a result
    sac_buf2 u_buf (
        .clock     (clock),
        .rst_n     (rst_n_q),
        .flush     (cs_rise),
        .in_data   (result),
        .in_valid  (st_q == `SAC_ST_PUSH),
        .in_ready  (buf_in_ready),
        .out_data  (buf_data),
        .out_valid (buf_valid),
        .out_ready (~loaded_q)
    );

    // ==========================================================
    // serial readout
    reg [`SAC_MSB:0] sh_q; // bits still to present
    always @(posedge clock or negedge rst_n_q) begin
        if (!rst_n_q) begin
            sh_q      <= `SAC_CODE_ZERO;
            loaded_q  <= 1'b0;
            nbit_q    <= `SAC_BITS_FULL;
            dout_q    <= 1'b0;
            dout_oe_q <= 1'b0;
        end else if (cs_rise) begin
            loaded_q  <= 1'b0;
            nbit_q    <= `SAC_CNT_ZERO;
            dout_q    <= 1'b0;
            dout_oe_q <= 1'b1;
        end else if (buf_valid && !loaded_q) begin
            // msb appears as soon as the result lands
            loaded_q  <= 1'b1;
            dout_q    <= buf_data[`SAC_MSB];
            sh_q      <= {buf_data[`SAC_MSB-1:0], 1'b0};
            dout_oe_q <= 1'b1;
        end else if (loaded_q) begin
            if (sck_rise && (nbit_q < `SAC_BITS_FULL)) begin
                nbit_q <= nbit_q + `SAC_CNT_ONE;
                if (nbit_q == `SAC_BITS_DATA - `SAC_CNT_ONE)
                    dout_oe_q <= 1'b0;
            end
            if (sck_fall && dout_oe_q) begin
                dout_q <= sh_q[`SAC_MSB];
                sh_q   <= {sh_q[`SAC_MSB-1:0], 1'b0};
            end
        end
    end

endmodule

//--- logic/sac_defines.vh
// constants shared by the converter control design
`ifndef SAC_DEFINES_VH
`define SAC_DEFINES_VH

// ==========================================================
// result and readout
`define SAC_DW          10      // result width in bits
`define SAC_MSB         9       // index of the result msb
`define SAC_MSB_TRIAL   10'h200 // first trial code of the approximation
`define SAC_ONE_TRIAL   10'h001 // lsb trial weight
`define SAC_BITS_FULL   4'hc    // bits that count as a full read
`define SAC_BITS_DATA   4'ha    // data bits before the output is released
`define SAC_CNT_ZERO    4'h0    // cleared bit count
`define SAC_CNT_ONE     4'h1    // bit count step
`define SAC_CODE_ZERO   10'h000 // cleared result or trial code

// ==========================================================
// result buffer fill levels
`define SAC_BUF_EMPTY   2'h0    // no entry held
`define SAC_BUF_ONE     2'h1    // fill count step
`define SAC_BUF_FULL    2'h2    // both entries held

// ==========================================================
// conversion timing
`define SAC_CLK_MHZ     25      // system clock rate in mhz
`define SAC_CONV_NS     3700    // longest start-to-msb time in ns
`define SAC_CONV_CYC    ((`SAC_CONV_NS * `SAC_CLK_MHZ) / 1000) // rounded down
`define SAC_CONV_SLACK  8       // cycles kept for sync, push and load
`define SAC_BIT_CYC     ((`SAC_CONV_CYC - `SAC_CONV_SLACK) / `SAC_DW)

// ==========================================================
// control states
`define SAC_ST_SHUT     2'h0    // powered down
`define SAC_ST_TRACK    2'h1    // sampling capacitors follow the inputs
`define SAC_ST_CONV     2'h2    // approximation running on held sample
`define SAC_ST_PUSH     2'h3    // result waiting for buffer room

`endif

//--- tb/sac_ctrl_props.sv
// checker of the converter control pins
`timescale 1ns/1ns
module sac_ctrl_props (
    input wire       clock,             // system clock
    input wire       arst_n,            // reset, active low
    input wire       convert_start_pin, // start pin
    input wire       serial_clock,      // serial clock pin
    input wire       diff_part,         // variant strap
    input wire       powered_q,         // core powered
    input wire       track_q,           // tracking
    input wire       pos_to_second_q,   // second channel
    input wire       neg_to_input_q,    // negative cap on input
    input wire       bipolar_q,         // bipolar coding
    input wire [9:0] dac_code_q,        // trial code
    input wire       dout_q,            // serial data
    input wire       dout_oe_q          // serial data enable
);
    logic [7:0] sck_hist_q; // recent serial clock samples
    // ==========================================
    // serial clock history
    always @(posedge clock or negedge arst_n) begin
        if (!arst_n) begin
            sck_hist_q <= 8'h00;
        end else begin
            sck_hist_q <= {sck_hist_q[6:0], serial_clock};
        end
    end
    default clocking cb @(posedge clock); endclocking
    default disable iff (!arst_n);
    // ==========================================
    // sequences and properties
    sequence s_acq_fall; // fall after a full acquisition
        $fell(convert_start_pin) && track_q && $past(convert_start_pin, 10);
    endsequence
    sequence s_result; // shut down with msb driven
        !powered_q && dout_oe_q && !track_q;
    endsequence
    property p_rise_track;
        $rose(convert_start_pin) |-> ##[2:5] (track_q && powered_q && dout_oe_q && !dout_q);
    endproperty
    property p_fall_hold;
        $fell(convert_start_pin) && track_q |-> ##[2:5] (!track_q && dac_code_q == 10'h200);
    endproperty
    property p_done_shut;
        s_acq_fall |-> ##[1:92] s_result;
    endproperty
    property p_track_power;
        track_q |-> powered_q;
    endproperty
    property p_mode_stable;
        !$rose(track_q) |-> $stable(pos_to_second_q) && $stable(bipolar_q);
    endproperty
    property p_neg_cap;
        track_q |-> neg_to_input_q == diff_part;
    endproperty
    property p_sel_var;
        track_q |-> (diff_part ? !pos_to_second_q : !bipolar_q);
    endproperty
    property p_oe_release;
        $fell(dout_oe_q) |-> (|sck_hist_q);
    endproperty
    property p_dac_step;
        $changed(dac_code_q) && !track_q |->
            ##1 ($stable(dac_code_q) || !powered_q || track_q)[*6];
    endproperty
    a_rise_track: assert property (p_rise_track) else $error("no tracking after rise");
    a_fall_hold: assert property (p_fall_hold) else $error("no hold after fall");
    a_done_shut: assert property (p_done_shut) else $error("msb late");
    a_track_power: assert property (p_track_power) else $error("tracking unpowered");
    a_mode_stable: assert property (p_mode_stable) else $error("mode moved");
    a_neg_cap: assert property (p_neg_cap) else $error("negative cap wrong");
    a_sel_var: assert property (p_sel_var) else $error("selection wrong");
    a_oe_release: assert property (p_oe_release) else $error("release off clock");
    a_dac_step: assert property (p_dac_step) else $error("trial code too fast");
endmodule

//--- tb/sac_ctrl_tb.sv
// testbench of the converter control
`timescale 1ns/1ns
module sac_ctrl_tb;
    logic       clock, arst_n, diff_part, last_q; // stimulus and wire memory
    logic       convert_start_pin, serial_clock;  // host pins
    logic [9:0] first_analog_channel, second_analog_channel, dac_code_q;           // analog levels, trial code
    logic       powered_q, track_q, pos_to_second_q, neg_to_input_q;
    logic       bipolar_q, dout_q, dout_oe_q;     // design outputs
    wire        cmp_hi = (pos_to_second_q ? second_analog_channel : first_analog_channel) >= dac_code_q;
    wire        dout_w = dout_oe_q ? dout_q : ~last_q; // released wire
    int         error_cnt = 0, n_tests = 0;       // counters
    sac_ctrl dut (.clock(clock), .arst_n(arst_n), .convert_start_pin(convert_start_pin),
        .serial_clock(serial_clock), .diff_part(diff_part), .cmp_hi(cmp_hi),
        .powered_q(powered_q), .track_q(track_q), .pos_to_second_q(pos_to_second_q),
        .neg_to_input_q(neg_to_input_q), .bipolar_q(bipolar_q), .dac_code_q(dac_code_q),
        .dout_q(dout_q), .dout_oe_q(dout_oe_q));
    sac_host host (.clock(clock), .dout_w(dout_w), .start_pin(convert_start_pin),
        .sck(serial_clock));
    initial begin
        clock = 1'b0;
        forever #20 clock = ~clock;
    end
    // memory of the data wire, so a released wire shows the inverse
    always @(posedge clock or negedge arst_n) begin
        if (!arst_n)
            last_q <= 1'b0;
        else
            last_q <= dout_w;
    end
    task automatic cmp_bit(input logic got, input logic exp);
        n_tests++;
        if (got !== exp) begin
            error_cnt++;
            $display("mismatch at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic cmp_word(input logic [9:0] got, input logic [9:0] exp);
        n_tests++;
        if (got !== exp) begin
            error_cnt++;
            $display("mismatch at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic conclude();
        $display("tests %0d errors %0d", n_tests, error_cnt);
        if (error_cnt == 0 && n_tests > 0) $display("Regression OK");
        else $display("Regression broken");
        $finish;
    endtask
    // one conversion, nread bits read, checked against exp and mode alt
    task automatic conv(input logic dbl, input int nread, input logic [9:0] exp,
                        input logic alt);
        logic [11:0] bits;
        host.rise(dbl);
        cmp_bit(track_q & powered_q & dout_oe_q & ~dout_q, 1'b1);
        cmp_bit(diff_part ? bipolar_q : pos_to_second_q, alt);
        cmp_bit(neg_to_input_q, diff_part);
        host.fall();
        cmp_bit(track_q | powered_q, 1'b0);
        cmp_bit(dout_oe_q, 1'b1);
        cmp_bit(dout_q, exp[9]);
        host.read(nread, bits);
        if (nread == 12) begin
            cmp_word(bits[11:2], exp);
            cmp_bit(dout_oe_q, 1'b0);
        end else begin
            cmp_word({5'h00, bits[4:0]}, {5'h00, exp[9:5]});
        end
    endtask
    task automatic s_reset();
        cmp_bit(powered_q | track_q | dout_oe_q, 1'b0);
    endtask
    task automatic s_channels();
        conv(1'b0, 12, 10'h2a5, 1'b0);
        conv(1'b0, 5, 10'h2a5, 1'b0);
        conv(1'b0, 12, 10'h15a, 1'b1);
        conv(1'b1, 12, 10'h15a, 1'b1);
    endtask
    task automatic s_bipolar();
        diff_part <= 1'b1;
        first_analog_channel <= 10'h3ff;
        host.hold(8);
        conv(1'b0, 12, 10'h3ff, 1'b0);
        conv(1'b1, 12, 10'h1ff, 1'b1);
    endtask
    initial begin
        arst_n = 1'b0;
        diff_part = 1'b0;
        first_analog_channel = 10'h2a5;
        second_analog_channel = 10'h15a;
        repeat (16) @(posedge clock);
        arst_n <= 1'b1;
        host.hold(6);
        s_reset();
        s_channels();
        s_bipolar();
        conclude();
    end
    initial begin
        #400000;
        error_cnt++;
        conclude();
    end
endmodule
bind sac_ctrl sac_ctrl_props u_props (.clock(clock), .arst_n(arst_n),
    .convert_start_pin(convert_start_pin), .serial_clock(serial_clock),
    .diff_part(diff_part), .powered_q(powered_q), .track_q(track_q),
    .pos_to_second_q(pos_to_second_q), .neg_to_input_q(neg_to_input_q),
    .bipolar_q(bipolar_q), .dac_code_q(dac_code_q), .dout_q(dout_q), .dout_oe_q(dout_oe_q));

//--- tb/sac_host.sv
// host model: start pin and serial master
`timescale 1ns/1ns
module sac_host (
    input wire   clock,     // system clock
    input wire   dout_w,    // resolved serial data wire
    output logic start_pin, // convert start pin
    output logic sck        // serial clock, still between frames
);
    initial begin
        start_pin = 1'b0;
        sck = 1'b0;
    end
    task automatic hold(input int n);
        repeat (n) @(posedge clock);
    endtask
    // raise the pin and acquire for 1.4 us
    task automatic rise(input logic dbl);
        if (dbl) begin
            start_pin <= 1'b1;
            hold(3);
            start_pin <= 1'b0;
            hold(3);
        end
        start_pin <= 1'b1;
        hold(35);
    endtask
    // hold edge, then wait out the 3.7 us conversion
    task automatic fall();
        start_pin <= 1'b0;
        hold(93);
    endtask
    // n bits at 320 ns period, taken in the high phase
    task automatic read(input int n, output logic [11:0] bits);
        bits = 12'h000;
        for (int i = 0; i < n; i++) begin
            sck <= 1'b1;
            hold(2);
            bits = {bits[10:0], dout_w};
            hold(2);
            sck <= 1'b0;
            hold(4);
        end
    endtask
endmodule
